/* hdl/uthd_baud.sv */
// uthd_baud: sixteen-times sample tick from integer divisor plus fraction/16.
// assumes the serial clock is the block clock; divisor zero stops the ticks.
`timescale 1ns/1ps
`default_nettype none
module uthd_baud
   import uthd_pkg::*;
(
   // clock, reset, enable
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   input  wire logic                    ce_i,
   // divisor setting
   input  wire logic [UTHD_DIV_W-1:0]   div_i,
   input  wire logic [UTHD_FRAC_W-1:0]  frac_i,
   // one-cycle sample tick
   output logic                         tick_o
);
   typedef struct packed {
      logic [UTHD_DIV_W-1:0]  cnt;
      logic [UTHD_FRAC_W-1:0] acc;
      logic                   tick;
   } uthd_baud_state_type;

   uthd_baud_state_type q, d;
   logic [UTHD_FRAC_W:0] sum;

   // fraction accumulator stretches every period whose sum carries, so the
   // mean period is div + frac/16 clocks at the cost of one-cycle jitter
   always_comb
   begin
      d      = q;
      d.tick = 1'b0;
      sum    = {1'b0, q.acc} + {1'b0, frac_i};
      if (div_i == '0)
      begin
         d.cnt = '0;
      end
      else if (q.cnt == '0)
      begin
         d.acc  = sum[UTHD_FRAC_W-1:0];                                // RL5
         d.cnt  = div_i - 16'h0001 + {15'h0000, sum[UTHD_FRAC_W]};     // RL5
         d.tick = 1'b1;
      end
      else
      begin
         d.cnt = q.cnt - 16'h0001;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)   q <= '0;
      else if (ce_i) q <= d;
   end

   assign tick_o = q.tick;

   // helper: cycles since the previous tick, valid once settings held still
   logic [UTHD_DIV_W:0]    gap_q;
   logic                   seen_q;
   logic [UTHD_DIV_W-1:0]  div_last_q;
   logic [UTHD_FRAC_W-1:0] frac_last_q;
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         gap_q       <= '0;
         seen_q      <= 1'b0;
         div_last_q  <= '0;
         frac_last_q <= '0;
      end
      else if (ce_i)
      begin
         div_last_q  <= div_i;
         frac_last_q <= frac_i;
         gap_q       <= q.tick ? 17'h00001 : gap_q + 17'h00001;
         if (div_i != div_last_q || frac_i != frac_last_q) seen_q <= 1'b0;
         else if (q.tick)                                  seen_q <= 1'b1;
      end
   end

   a_tick_spacing: assert property (@(posedge clk_i) disable iff (reset_i) // RL5
      (ce_i && q.tick && seen_q && div_i == div_last_q && frac_i == frac_last_q && div_i != '0)
      |-> (gap_q == {1'b0, div_i} || (gap_q == {1'b0, div_i} + 17'h00001 && frac_i != '0)))
      else $error("sample tick spacing is not div or div plus one");

endmodule : uthd_baud
`default_nettype wire

/* hdl/uthd_fifo.sv */
// uthd_fifo: transmit character fifo, show-ahead read port.
// assumes DEPTH is a power of two; push when full and pop when empty are dropped.
`timescale 1ns/1ps
`default_nettype none
module uthd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock, reset, enable
   input  wire logic                         clk_i,
   input  wire logic                         reset_i,
   input  wire logic                         ce_i,
   // control
   input  wire logic                         clr_i,
   input  wire logic                         push_i,
   input  wire logic [WIDTH-1:0]             wdata_i,
   input  wire logic                         pop_i,
   // status and head
   output logic      [WIDTH-1:0]             rdata_o,
   output logic                              empty_o,
   output logic                              full_o,
   output logic      [$clog2(DEPTH+1)-1:0]   level_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [CW-1:0] count;
   } uthd_fifo_state_type;

   uthd_fifo_state_type q, d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             do_push;
   logic             do_pop;

   // pointer and level bookkeeping; clear wins over everything
   always_comb
   begin
      d       = q;
      do_push = push_i && !full_o && !clr_i;
      do_pop  = pop_i && !empty_o && !clr_i;
      if (clr_i)
      begin
         d = '0;
      end
      else
      begin
         if (do_push) d.wr_ptr = q.wr_ptr + 1'b1;
         if (do_pop)  d.rd_ptr = q.rd_ptr + 1'b1;
         d.count = q.count + CW'(do_push) - CW'(do_pop);
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)   q <= '0;
      else if (ce_i) q <= d;
   end

   // storage needs no reset; only written slots are ever read
   always_ff @(posedge clk_i)
   begin
      if (ce_i && do_push) mem[q.wr_ptr] <= wdata_i;
   end

   assign rdata_o = mem[q.rd_ptr];
   assign empty_o = (q.count == '0);
   assign full_o  = (q.count == CW'(DEPTH));
   assign level_o = q.count;

endmodule : uthd_fifo
`default_nettype wire

/* hdl/uthd_pkg.sv */
// uthd_pkg: register map, field positions, reset values and state codes
// of the uart transmit-halt / dma-acknowledge / fractional-divisor block.
// assumes a 32-bit byte-addressed register port; every offset is word aligned.
package uthd_pkg;

   // register byte addresses
   localparam logic [31:0] UTHD_BUF_ADDR   = 32'h5002_0000; // rx data / tx push / divisor low
   localparam logic [31:0] UTHD_DIVHI_ADDR = 32'h5002_0004; // divisor high byte
   localparam logic [31:0] UTHD_FCR_ADDR   = 32'h5002_0008; // fifo enable
   localparam logic [31:0] UTHD_LCR_ADDR   = 32'h5002_000C; // divisor access bit
   localparam logic [31:0] UTHD_LSR_ADDR   = 32'h5002_0014; // line status
   localparam logic [31:0] UTHD_HTX_ADDR   = 32'h5002_00A4; // transmit_halt_control
   localparam logic [31:0] UTHD_DMASA_ADDR = 32'h5002_00A8; // dma_software_acknowledge
   localparam logic [31:0] UTHD_DLF_ADDR   = 32'h5002_00C0; // divisor_fraction
   localparam logic [31:0] UTHD_UCV_ADDR   = 32'h5002_00F8; // component_version
   localparam logic [31:0] UTHD_CTR_ADDR   = 32'h5002_00FC; // component_type

   // field positions
   localparam int UTHD_HALT_BIT     = 0;
   localparam int UTHD_ACK_BIT      = 0;
   localparam int UTHD_FIFO_EN_BIT  = 0;
   localparam int UTHD_DAB_BIT      = 7;
   localparam int UTHD_FRAC_MSB     = 3;
   localparam int UTHD_LSR_RDY_BIT  = 0;
   localparam int UTHD_LSR_EMPT_BIT = 5;
   localparam int UTHD_LSR_IDLE_BIT = 6;

   // widths and reset values
   localparam int         UTHD_FRAC_W     = 4;
   localparam int         UTHD_DIV_W      = 16;
   localparam logic [7:0] UTHD_BYTE_RESET = 8'h00;
   localparam logic [3:0] UTHD_FRAC_RESET = 4'h0;
   localparam logic [31:0] UTHD_ZERO_WORD = 32'h0000_0000;

   // bit timing: sixteen sample ticks per bit
   localparam logic [3:0] UTHD_SUB_LAST   = 4'hF;
   localparam logic [3:0] UTHD_SUB_MID    = 4'h7;
   localparam logic [2:0] UTHD_DATA_LAST  = 3'h7;
   localparam logic [3:0] UTHD_RX_FIRST   = 4'h1;
   localparam logic [3:0] UTHD_RX_STOP    = 4'h9;

   // transmit sequencer states
   typedef enum logic [3:0] {
      UTHD_TX_IDLE  = 4'b0001,
      UTHD_TX_START = 4'b0010,
      UTHD_TX_DATA  = 4'b0100,
      UTHD_TX_STOP  = 4'b1000
   } uthd_tx_state_type;

endpackage : uthd_pkg

/* hdl/uthd_top.sv */
// uthd_top: uart core with transmit halt, dma software acknowledge and
// fractional baud divisor, reached over a plain address/strobe register port.
// assumes strobes one cycle wide and synchronous rxd; read data valid one cycle later.
// Notes on behaviour
// RL1: halt bit set with fifos enabled stops new characters from starting.
// RL2: with fifos disabled the halt bit has no effect at all.
// RL3: writing one to the acknowledge bit drops all four dma request lines.
// RL4: acknowledge bit clears itself, is write only, always reads zero.
// RL5: fraction field over sixteen is added to the sixteen-bit integer divisor.
// RL6: baud is clock over sixteen times divisor; divisor low needs access bit.
// RL7: while halted, fifo keeps filling, receiver runs, sending resumes on clear.
`timescale 1ns/1ps
`default_nettype none
module uthd_top
   import uthd_pkg::*;
#(
   parameter int          FIFO_DEPTH   = 16,
   parameter logic [31:0] VERSION_CODE = 32'h0000_0100, // arbitrary value
   parameter logic [31:0] TYPE_CODE    = 32'h0000_0200  // arbitrary value
) (
   // clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        ce_i,
   // register port
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        we_i,
   input  wire logic        re_i,
   output logic      [31:0] rdata_o,
   // serial line
   input  wire logic        rxd_i,
   output logic             txd_o,
   // dma handshake lines, active high
   output logic             dma_tx_req_o,
   output logic             dma_tx_single_o,
   output logic             dma_rx_req_o,
   output logic             dma_rx_single_o
);
   localparam int CW = $clog2(FIFO_DEPTH+1);

   typedef struct packed {
      uthd_tx_state_type tx_st;
      logic [3:0]        tx_sub;
      logic [2:0]        tx_bit;
      logic [7:0]        tx_shift;
      logic              rx_busy;
      logic [3:0]        rx_sub;
      logic [3:0]        rx_bit;
      logic [7:0]        rx_shift;
      logic [7:0]        rx_data;
      logic              rx_ready;
      logic [7:0]        dll;
      logic [7:0]        div_hi;
      logic              dab;
      logic              fifo_en;
      logic              halt;
      logic [3:0]        frac;
      logic              tx_sup;
      logic              rx_sup;
      logic [31:0]       rdata;
      logic              txd;
      logic              tx_req;
      logic              tx_single;
      logic              rx_req;
      logic              rx_single;
   } uthd_state_type;

   localparam uthd_state_type RESET_STATE = '{
      tx_st: UTHD_TX_IDLE, tx_sub: '0, tx_bit: '0, tx_shift: UTHD_BYTE_RESET,
      rx_busy: 1'b0, rx_sub: '0, rx_bit: '0, rx_shift: UTHD_BYTE_RESET,
      rx_data: UTHD_BYTE_RESET, rx_ready: 1'b0, dll: UTHD_BYTE_RESET,
      div_hi: UTHD_BYTE_RESET, dab: 1'b0, fifo_en: 1'b0, halt: 1'b0,
      frac: UTHD_FRAC_RESET, tx_sup: 1'b0, rx_sup: 1'b0, rdata: UTHD_ZERO_WORD,
      txd: 1'b1, tx_req: 1'b0, tx_single: 1'b0, rx_req: 1'b0, rx_single: 1'b0};

   uthd_state_type q, d;
   logic           tick;
   logic           push;
   logic           pop;
   logic           clr;
   logic           ack;
   logic           halted;
   logic [7:0]     fifo_head;
   logic           fifo_empty;
   logic           fifo_full;
   logic [CW-1:0]  fifo_level;

   // transmit character store
   uthd_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .ce_i    (ce_i),
      .clr_i   (clr),
      .push_i  (push),
      .wdata_i (wdata_i[7:0]),
      .pop_i   (pop),
      .rdata_o (fifo_head),
      .empty_o (fifo_empty),
      .full_o  (fifo_full),
      .level_o (fifo_level)
   );

   // sample tick from divisor high/low plus fraction
   uthd_baud u_baud (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .ce_i    (ce_i),
      .div_i   ({q.div_hi, q.dll}),                                    // RL6
      .frac_i  (q.frac),                                               // RL5
      .tick_o  (tick)
   );

   // halt only counts while fifos are on
   assign halted = q.fifo_en && q.halt;                                // RL1 RL2

   // next state: register port first, then line engines, then dma lines
   always_comb
   begin
      d       = q;
      push    = 1'b0;
      pop     = 1'b0;
      clr     = 1'b0;
      ack     = 1'b0;
      d.rdata = UTHD_ZERO_WORD;

      // register writes
      if (we_i)
      begin
         case (addr_i)
            UTHD_BUF_ADDR:
               if (q.dab) d.dll = wdata_i[7:0];                        // RL6
               else       push  = 1'b1;                                // RL7
            UTHD_DIVHI_ADDR:
               if (q.dab) d.div_hi = wdata_i[7:0];
            UTHD_FCR_ADDR:
            begin
               d.fifo_en = wdata_i[UTHD_FIFO_EN_BIT];
               clr       = q.fifo_en && !wdata_i[UTHD_FIFO_EN_BIT];
            end
            UTHD_LCR_ADDR:   d.dab  = wdata_i[UTHD_DAB_BIT];
            UTHD_HTX_ADDR:   d.halt = wdata_i[UTHD_HALT_BIT];           // RL1
            UTHD_DMASA_ADDR: ack    = wdata_i[UTHD_ACK_BIT];            // RL3 RL4
            UTHD_DLF_ADDR:   d.frac = wdata_i[UTHD_FRAC_MSB:0];         // RL5
            default: ;
         endcase
      end

      // register reads, answered in the following cycle only
      if (re_i)
      begin
         case (addr_i)
            UTHD_BUF_ADDR:
               if (q.dab) d.rdata = {24'h000000, q.dll};                // RL6
               else
               begin
                  d.rdata    = {24'h000000, q.rx_data};
                  d.rx_ready = 1'b0;
               end
            UTHD_DIVHI_ADDR: if (q.dab) d.rdata = {24'h000000, q.div_hi};
            UTHD_FCR_ADDR: d.rdata[UTHD_FIFO_EN_BIT] = q.fifo_en;
            UTHD_LCR_ADDR: d.rdata[UTHD_DAB_BIT] = q.dab;
            UTHD_LSR_ADDR:
            begin
               d.rdata[UTHD_LSR_RDY_BIT]  = q.rx_ready;
               d.rdata[UTHD_LSR_EMPT_BIT] = fifo_empty;
               d.rdata[UTHD_LSR_IDLE_BIT] = fifo_empty && q.tx_st == UTHD_TX_IDLE;
            end
            UTHD_HTX_ADDR: d.rdata[UTHD_HALT_BIT] = q.halt;
            UTHD_DLF_ADDR: d.rdata[UTHD_FRAC_MSB:0] = q.frac;
            UTHD_UCV_ADDR: d.rdata = VERSION_CODE;
            UTHD_CTR_ADDR: d.rdata = TYPE_CODE;
            default: ;                                                 // acknowledge reads zero RL4
         endcase
      end

      // transmitter: eight data bits, no parity, one stop bit
      unique case (q.tx_st)
         UTHD_TX_IDLE:
            if (!fifo_empty && !halted)                                // RL1 RL2 RL7
            begin
               pop        = 1'b1;
               d.tx_shift = fifo_head;
               d.tx_st    = UTHD_TX_START;
               d.tx_sub   = '0;
               d.tx_bit   = '0;
               d.txd      = 1'b0;
            end
         UTHD_TX_START:
            if (tick)
            begin
               d.tx_sub = q.tx_sub + 4'h1;
               if (q.tx_sub == UTHD_SUB_LAST)
               begin
                  d.tx_st = UTHD_TX_DATA;
                  d.txd   = q.tx_shift[0];
               end
            end
         UTHD_TX_DATA:
            if (tick)
            begin
               d.tx_sub = q.tx_sub + 4'h1;
               if (q.tx_sub == UTHD_SUB_LAST)
               begin
                  d.tx_shift = {1'b0, q.tx_shift[7:1]};
                  d.tx_bit   = q.tx_bit + 3'h1;
                  if (q.tx_bit == UTHD_DATA_LAST)
                  begin
                     d.tx_st = UTHD_TX_STOP;
                     d.txd   = 1'b1;
                  end
                  else
                  begin
                     d.txd = q.tx_shift[1];
                  end
               end
            end
         UTHD_TX_STOP:
            if (tick)
            begin
               d.tx_sub = q.tx_sub + 4'h1;
               if (q.tx_sub == UTHD_SUB_LAST) d.tx_st = UTHD_TX_IDLE;
            end
      endcase

      // receiver keeps running regardless of halt; a false start is dropped
      if (!q.rx_busy)
      begin
         if (!rxd_i)                                                   // RL7
         begin
            d.rx_busy = 1'b1;
            d.rx_sub  = '0;
            d.rx_bit  = '0;
         end
      end
      else if (tick)
      begin
         d.rx_sub = q.rx_sub + 4'h1;
         if (q.rx_bit == '0 && q.rx_sub == UTHD_SUB_MID)
         begin
            d.rx_sub  = '0;
            d.rx_bit  = UTHD_RX_FIRST;
            d.rx_busy = !rxd_i;
         end
         else if (q.rx_bit != '0 && q.rx_sub == UTHD_SUB_LAST)
         begin
            d.rx_bit = q.rx_bit + 4'h1;
            if (q.rx_bit == UTHD_RX_STOP)
            begin
               d.rx_busy = 1'b0;
               if (rxd_i)
               begin
                  // new byte beats a same-cycle read clear
                  d.rx_data  = q.rx_shift;
                  d.rx_ready = 1'b1;
                  d.rx_sup   = 1'b0;
               end
            end
            else
            begin
               d.rx_shift = {rxd_i, q.rx_shift[7:1]};
            end
         end
      end

      // dma lines: rearm on next push or byte, acknowledge overrides both
      if (push) d.tx_sup = 1'b0;
      if (ack)
      begin
         d.tx_sup = 1'b1;                                              // RL3
         d.rx_sup = 1'b1;                                              // RL3
      end
      d.tx_single = !d.tx_sup && !fifo_full;
      d.tx_req    = !d.tx_sup && fifo_level <= CW'(FIFO_DEPTH / 2);
      d.rx_single = !d.rx_sup && d.rx_ready;
      d.rx_req    = !d.rx_sup && d.rx_ready;
   end

   // single state register; enable low freezes everything
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)   q <= RESET_STATE;
      else if (ce_i) q <= d;
   end

   assign rdata_o         = q.rdata;
   assign txd_o           = q.txd;
   assign dma_tx_req_o    = q.tx_req;
   assign dma_tx_single_o = q.tx_single;
   assign dma_rx_req_o    = q.rx_req;
   assign dma_rx_single_o = q.rx_single;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_halt_holds_idle: assert property (                                // RL1
      ce_i && halted && q.tx_st == UTHD_TX_IDLE |=> q.tx_st == UTHD_TX_IDLE)
      else $error("transmitter started while halted");

   a_halt_ignored_off: assert property (                               // RL2
      ce_i && !q.fifo_en && q.halt && q.tx_st == UTHD_TX_IDLE && !fifo_empty
      |=> q.tx_st == UTHD_TX_START && !txd_o)
      else $error("halt bit blocked transmission with fifos disabled");

   a_ack_drops_dma: assert property (                                  // RL3
      ce_i && we_i && addr_i == UTHD_DMASA_ADDR && wdata_i[UTHD_ACK_BIT]
      |=> !dma_tx_req_o && !dma_tx_single_o && !dma_rx_req_o && !dma_rx_single_o)
      else $error("dma lines still active after acknowledge");

   a_ack_reads_zero: assert property (                                 // RL4
      ce_i && re_i && addr_i == UTHD_DMASA_ADDR |=> rdata_o == UTHD_ZERO_WORD)
      else $error("acknowledge register did not read zero");

   a_dll_gated_read: assert property (                                 // RL6
      ce_i && re_i && addr_i == UTHD_BUF_ADDR && q.dab
      |=> rdata_o == {24'h000000, $past(q.dll)})
      else $error("divisor low not returned with access bit set");

   a_dll_write_gated: assert property (                                // RL6
      ce_i && we_i && addr_i == UTHD_BUF_ADDR && !q.dab |=> $stable(q.dll))
      else $error("divisor low changed without access bit");

   a_fill_while_halt: assert property (                                // RL7
      ce_i && halted && q.tx_st == UTHD_TX_IDLE && push && !fifo_full && !clr
      |=> !fifo_empty ##0 q.tx_st == UTHD_TX_IDLE)
      else $error("push lost while transmission halted");

   c_halted_fill: cover property (halted && push ##1 !fifo_empty [*2]);
   c_ack_seen: cover property (dma_tx_single_o ##1 ack ##1 !dma_tx_single_o);
   c_byte_received: cover property ($rose(q.rx_ready));
   c_frame_sent: cover property (q.tx_st == UTHD_TX_STOP ##1 q.tx_st == UTHD_TX_IDLE);

endmodule : uthd_top
`default_nettype wire

/* sim/testbench.sv */
// testbench: register port driver, queued expectations, line model on txd/rxd.
// assumes the register map of uthd_pkg and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import uthd_pkg::*;
;
   localparam logic [31:0] VER = 32'h0000_0A5A; // arbitrary value
   localparam logic [31:0] TYP = 32'h0000_0C3C; // arbitrary value
   logic        clk_i = 1'b0, reset_i = 1'b1, we_i = 1'b0, re_i = 1'b0, re_q = 1'b0, ce = 1'b1;
   logic [31:0] addr_i = '0, wdata_i = '0, rdata_o;
   logic        rxd_i, txd_o, txr, txs, rxr, rxs, send = 1'b0, got_v;
   logic [7:0]  send_b = '0, bit_clks = 8'h10, hb [3];
   logic [8:0]  got_b;
   logic [31:0] rq [$], tq [$];
   int          err_total = 0, comparisons = 0, cycles = 0;
   logic [15:0] dv [3] = '{16'h0001, 16'h0002, 16'h0001};
   logic [3:0]  fr [3] = '{4'h0, 4'h0, 4'h8};
   logic [7:0]  bc [3] = '{8'h10, 8'h20, 8'h18};

   uthd_top #(.FIFO_DEPTH(16), .VERSION_CODE(VER), .TYPE_CODE(TYP)) dut_u (
      .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
      .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o),
      .dma_tx_req_o(txr), .dma_tx_single_o(txs), .dma_rx_req_o(rxr), .dma_rx_single_o(rxs));

   uthd_line_model line_u (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .bit_clks_i(bit_clks),
      .send_i(send), .send_byte_i(send_b), .frame_o(got_b), .valid_o(got_v));

   // 40 ns period
   always #20 clk_i = ~clk_i;

   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : check

   // decoded frame, stop bit over data byte
   task automatic check_frame(input logic [31:0] exp, input logic [8:0] got);
      check(exp, {23'h0, got});
   endtask : check_frame

   task automatic conclude();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // one-cycle strobe, one idle cycle after it
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      we_i <= w;
      re_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      we_i <= 1'b0;
      re_i <= 1'b0;
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      bus(1'b0, a, '0);
   endtask : rd

   task automatic set_div(input logic [15:0] dvs, input logic [3:0] frac);
      wr(UTHD_LCR_ADDR, 32'h0000_0080);
      wr(UTHD_BUF_ADDR, {24'h0, dvs[7:0]});
      wr(UTHD_DIVHI_ADDR, {24'h0, dvs[15:8]});
      rd(UTHD_BUF_ADDR, {24'h0, dvs[7:0]});
      wr(UTHD_LCR_ADDR, '0);
      rd(UTHD_DIVHI_ADDR, '0);
      wr(UTHD_DLF_ADDR, {28'h0, frac});
      rd(UTHD_DLF_ADDR, {28'h0, frac});
   endtask : set_div

   task automatic push(input logic [7:0] b);
      tq.push_back({23'h0, 1'b1, b});
      wr(UTHD_BUF_ADDR, {24'h0, b});
   endtask : push

   // result watcher: read data and decoded frames against the oldest note
   always @(posedge clk_i)
   begin
      re_q <= re_i;
      if (re_q)
         check(rq.pop_front(), rdata_o);
      if (got_v)
         check_frame(tq.size() ? tq.pop_front() : 32'hDEAD, got_b);
      cycles++;
      if (cycles == 40000)
      begin
         err_total++;
         conclude();
      end
   end

   initial
   begin
      void'($urandom(30));
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(UTHD_UCV_ADDR, VER);
      rd(UTHD_CTR_ADDR, TYP);
      rd(UTHD_DMASA_ADDR, '0);
      rd(UTHD_DLF_ADDR, '0);
      rd(32'h5002_00B0, '0);
      wr(UTHD_FCR_ADDR, 32'h1);
      // integer and fractional divisors
      for (int i = 0; i < 3; i++)
      begin
         set_div(dv[i], fr[i]);
         bit_clks = bc[i];
         push(8'($urandom));
         wait (tq.size() == 0);
         repeat (40) @(posedge clk_i);
      end
      // halt: fifo fills, line stays idle, receiver keeps working
      wr(UTHD_HTX_ADDR, 32'h1);
      rd(UTHD_HTX_ADDR, 32'h1);
      for (int i = 0; i < 3; i++)
      begin
         hb[i] = 8'($urandom);
         wr(UTHD_BUF_ADDR, {24'h0, hb[i]});
      end
      send_b <= 8'($urandom);
      send <= 1'b1;
      @(posedge clk_i);
      send <= 1'b0;
      wait (rxr === 1'b1);
      check(32'h1, {31'h0, txd_o});
      wr(UTHD_DMASA_ADDR, 32'h1);
      #1 check(32'h0, {28'h0, txr, txs, rxr, rxs});
      rd(UTHD_DMASA_ADDR, '0);
      rd(UTHD_BUF_ADDR, {24'h0, send_b});
      for (int i = 0; i < 3; i++)
         tq.push_back({23'h0, 1'b1, hb[i]});
      wr(UTHD_HTX_ADDR, '0);
      wait (tq.size() == 0);
      // fifos off: halt ignored
      wr(UTHD_FCR_ADDR, '0);
      wr(UTHD_HTX_ADDR, 32'h1);
      push(8'($urandom));
      wait (tq.size() == 0);
      repeat (40) @(posedge clk_i);
      // enable low freezes state, so this write is lost
      ce <= 1'b0;
      wr(UTHD_HTX_ADDR, '0);
      ce <= 1'b1;
      rd(UTHD_HTX_ADDR, 32'h1);
      repeat (2) @(posedge clk_i);
      conclude();
   end
endmodule : testbench
`default_nettype wire

/* sim/uthd_line_model.sv */
// uthd_line_model: far end of the serial line, decodes txd frames, sends rx frames.
// assumes 8N1 framing and a bit length in clocks given by the bench.
`timescale 1ns/1ps
`default_nettype none
module uthd_line_model (
   // clock and line
   input  wire logic       clk_i,
   input  wire logic       txd_i,
   output logic            rxd_o,
   // bit length in clocks
   input  wire logic [7:0] bit_clks_i,
   // send request
   input  wire logic       send_i,
   input  wire logic [7:0] send_byte_i,
   // decoded frame: stop bit over data
   output logic [8:0]      frame_o,
   output logic            valid_o
);
   initial rxd_o = 1'b1;
   initial valid_o = 1'b0;

   // receiver samples mid bit, so fractional tick jitter is tolerated
   always
   begin : rx_frame
      logic [8:0] sh;
      @(negedge txd_i);
      repeat (bit_clks_i / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++)
      begin
         repeat (bit_clks_i) @(posedge clk_i);
         sh[i] = txd_i;
      end
      frame_o <= sh;
      valid_o <= 1'b1;
      @(posedge clk_i);
      valid_o <= 1'b0;
   end

   // sender: line idles high between frames
   always
   begin : tx_frame
      logic [9:0] f;
      @(posedge clk_i);
      f = {1'b1, send_byte_i, 1'b0};
      if (send_i)
      begin
         for (int i = 0; i < 10; i++)
         begin
            rxd_o <= f[i];
            repeat (bit_clks_i) @(posedge clk_i);
         end
      end
   end
endmodule : uthd_line_model
`default_nettype wire
